// [common/cbfm_defines.svh]
// Purpose: Constants of the cell balancing flag and mask registers
// Assumes: 250 MHz system clock
// Notes: Included by the register bank, the checker, the host model and the testbench
`ifndef CBFM_DEFINES_SVH
`define CBFM_DEFINES_SVH

// Register byte addresses
`define CBFM_ADDR_FLAG 8'h2B
`define CBFM_ADDR_MASK 8'h2C

// Reset values
`define CBFM_FLAG_RST 8'h00
`define CBFM_MASK_RST 8'h00

// Enable bit positions in the flag register, event field width of both registers
`define CBFM_BIT_TOP_EN 7
`define CBFM_BIT_BOT_EN 6
`define CBFM_EVT_W 6

// I2C target address, value is arbitrary
`define CBFM_I2C_DEV_ADDR 7'h3C
`define CBFM_BITS_PER_BYTE 4'h8

// Interrupt pulse timing
`define CBFM_CLK_PERIOD_NS 4
`define CBFM_INT_PULSE_NS 1000
`define CBFM_INT_PULSE_CYC (`CBFM_INT_PULSE_NS / `CBFM_CLK_PERIOD_NS)

`endif

// [common/cbfm_pkg.sv]
// Purpose: Types of the cell balancing flag and mask registers
// Assumes: cbfm_defines.svh holds the numbers
// Notes: One-hot I2C target states
package cbfm_pkg;

  typedef enum logic [8:0]
  {
    CBFM_IDLE = 9'h001,
    CBFM_ADDR = 9'h002,
    CBFM_AACK = 9'h004,
    CBFM_PTR = 9'h008,
    CBFM_PACK = 9'h010,
    CBFM_WR = 9'h020,
    CBFM_WACK = 9'h040,
    CBFM_RD = 9'h080,
    CBFM_RACK = 9'h100
  } cbfm_state_t;

endpackage : cbfm_pkg

// [src/cbfm_regs.sv]
// Purpose: Cell balancing flag/control and mask registers behind an I2C target
// Assumes: SCL and SDA synchronous to clk_i; status inputs are levels
// Notes: Watchdog expiry has no path into these registers
`timescale 1ns/100ps
`include "cbfm_defines.svh"

// Contract
// - Top enable bit drives top discharge switch while auto_balance_enable_i is low
// - Bottom enable bit drives bottom discharge switch while auto_balance_enable_i is low
// - Balance entry or exit sets event flag
// - Constant-voltage flags set and stay latched
// - Over-voltage flags set and stay latched
// - Over-current flag sets and stays latched
// - Reading flags clears them unless condition persists
// - Balance event mask blocks its interrupt
// - Per-event masks block their interrupts
// - Mask reserved bits read zero, ignore writes
// - Flag register at 2Bh, resets zero
// - Mask register at 2Ch, resets zero
// - Balance active status edges feed event flag
module cbfm_regs
  import cbfm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // I2C pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Balancing status
  input wire logic balance_active_status_i,
  input wire logic upper_switch_constv_i,
  input wire logic lower_switch_constv_i,
  input wire logic upper_cell_overvolt_i,
  input wire logic lower_cell_overvolt_i,
  input wire logic balance_overcurrent_i,
  input wire logic auto_balance_enable_i,
  input wire logic reg_reset_i,
  // Outputs
  output logic top_discharge_switch_o,
  output logic bottom_discharge_switch_o,
  output logic int_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cbfm_state_t state_r;
  cbfm_state_t state_nxt;
  logic scl_q_r;
  logic sda_q_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [3:0] cnt_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic nack_r;
  logic sda_oe_r;
  logic [1:0] ctrl_r;
  logic [`CBFM_EVT_W-1:0] flag_r;
  logic [`CBFM_EVT_W-1:0] flag_nxt;
  logic [`CBFM_EVT_W-1:0] mask_r;
  logic [`CBFM_EVT_W-1:0] lvl_q_r;
  logic bal_q_r;
  logic [15:0] int_cnt_r;
  logic [15:0] int_cnt_nxt;
  logic int_n_r;
  logic top_sw_r;
  logic bot_sw_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode
  function automatic logic [7:0] cbfm_read(input logic [7:0] a, input logic [1:0] c,
                                           input logic [`CBFM_EVT_W-1:0] f,
                                           input logic [`CBFM_EVT_W-1:0] m);
    logic [7:0] d;
    d = 8'h00;
    if (a == `CBFM_ADDR_FLAG)
    begin
      d = {c, f};
    end
    else if (a == `CBFM_ADDR_MASK)
    begin
      d = {2'h0, m};
    end
    return d;
  endfunction : cbfm_read

  ////////////////////////////////////////////////////////////////////////////
  // Bus pin conditions
  wire scl_rise = scl_i & ~scl_q_r;
  wire scl_fall = ~scl_i & scl_q_r;
  wire bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
  wire bus_stop = scl_i & scl_q_r & ~sda_q_r & sda_i;
  wire byte_done = scl_fall & (cnt_r == `CBFM_BITS_PER_BYTE);
  wire addr_match = (shift_r[7:1] == `CBFM_I2C_DEV_ADDR);
  wire load_byte = scl_fall & ((state_r == CBFM_AACK & rw_r) | (state_r == CBFM_RACK & ~nack_r));
  wire [7:0] rd_data = cbfm_read(ptr_r, ctrl_r, flag_r, mask_r);
  wire wr_pulse = byte_done & (state_r == CBFM_WR);
  wire wr_flag = wr_pulse & (ptr_r == `CBFM_ADDR_FLAG);
  wire wr_mask = wr_pulse & (ptr_r == `CBFM_ADDR_MASK);
  wire rd_flag = load_byte & (ptr_r == `CBFM_ADDR_FLAG);

  ////////////////////////////////////////////////////////////////////////////
  // Event conditions
  wire bal_edge = balance_active_status_i ^ bal_q_r;
  wire [`CBFM_EVT_W-1:0] evt_lvl = {bal_edge, upper_switch_constv_i, lower_switch_constv_i,
                                    upper_cell_overvolt_i, lower_cell_overvolt_i, balance_overcurrent_i};
  wire [`CBFM_EVT_W-1:0] evt_new = {bal_edge, evt_lvl[`CBFM_EVT_W-2:0] & ~lvl_q_r[`CBFM_EVT_W-2:0]};
  wire irq_evt = |(evt_new & ~mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Next flags, set wins over read clear
  always_comb
  begin
    flag_nxt = (flag_r & ~{`CBFM_EVT_W{rd_flag}}) | evt_lvl;
    if (reg_reset_i)
    begin
      flag_nxt = `CBFM_EVT_W'(`CBFM_FLAG_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulse length
  always_comb
  begin
    int_cnt_nxt = 16'h0000;
    if (irq_evt)
    begin
      int_cnt_nxt = 16'(`CBFM_INT_PULSE_CYC);
    end
    else if (int_cnt_r != 16'h0000)
    begin
      int_cnt_nxt = int_cnt_r - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target state sequence
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      CBFM_IDLE: state_nxt = CBFM_IDLE;
      CBFM_ADDR: if (byte_done) state_nxt = addr_match ? CBFM_AACK : CBFM_IDLE;
      CBFM_AACK: if (scl_fall) state_nxt = rw_r ? CBFM_RD : CBFM_PTR;
      CBFM_PTR: if (byte_done) state_nxt = CBFM_PACK;
      CBFM_PACK: if (scl_fall) state_nxt = CBFM_WR;
      CBFM_WR: if (byte_done) state_nxt = CBFM_WACK;
      CBFM_WACK: if (scl_fall) state_nxt = CBFM_WR;
      CBFM_RD: if (byte_done) state_nxt = CBFM_RACK;
      CBFM_RACK: if (scl_fall) state_nxt = nack_r ? CBFM_IDLE : CBFM_RD;
      default: state_nxt = CBFM_IDLE;
    endcase
    if (bus_start)
    begin
      state_nxt = CBFM_ADDR;
    end
    else if (bus_stop)
    begin
      state_nxt = CBFM_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus side registers
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= CBFM_IDLE;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      scl_q_r <= scl_i;
      sda_q_r <= sda_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
    end
    else if (bus_start | (state_nxt != state_r))
    begin
      cnt_r <= 4'h0;
    end
    else if (scl_rise)
    begin
      cnt_r <= cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], sda_i};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      ptr_r <= 8'h00;
    end
    else
    begin
      if (byte_done & (state_r == CBFM_ADDR))
      begin
        rw_r <= shift_r[0];
      end
      if (scl_rise & (state_r == CBFM_RACK))
      begin
        nack_r <= sda_i;
      end
      if (byte_done & (state_r == CBFM_PTR))
      begin
        ptr_r <= shift_r;
      end
      else if (load_byte | wr_pulse)
      begin
        ptr_r <= ptr_r + 8'h01;
      end
    end
  end

  // Data pin drive: ack slots and read bits
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sda_oe_r <= 1'b0;
      tx_r <= 8'h00;
    end
    else if (bus_start | bus_stop)
    begin
      sda_oe_r <= 1'b0;
    end
    else if (load_byte)
    begin
      tx_r <= {rd_data[6:0], 1'b0};
      sda_oe_r <= ~rd_data[7];
    end
    else if (byte_done)
    begin
      sda_oe_r <= (state_r != CBFM_RD) & ((state_r != CBFM_ADDR) | addr_match);
    end
    else if (scl_fall & (state_r == CBFM_RD))
    begin
      tx_r <= {tx_r[6:0], 1'b0};
      sda_oe_r <= ~tx_r[7];
    end
    else if (scl_fall)
    begin
      sda_oe_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_r <= 2'h0;
      flag_r <= `CBFM_EVT_W'(`CBFM_FLAG_RST);
      mask_r <= `CBFM_EVT_W'(`CBFM_MASK_RST);
    end
    else
    begin
      flag_r <= flag_nxt;
      if (reg_reset_i)
      begin
        ctrl_r <= 2'h0;
        mask_r <= `CBFM_EVT_W'(`CBFM_MASK_RST);
      end
      else
      begin
        if (wr_flag)
        begin
          ctrl_r <= shift_r[`CBFM_BIT_TOP_EN:`CBFM_BIT_BOT_EN];
        end
        if (wr_mask)
        begin
          mask_r <= shift_r[`CBFM_EVT_W-1:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event history, interrupt and switch outputs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      lvl_q_r <= '0;
      bal_q_r <= 1'b0;
      int_cnt_r <= 16'h0000;
      int_n_r <= 1'b1;
      top_sw_r <= 1'b0;
      bot_sw_r <= 1'b0;
    end
    else
    begin
      lvl_q_r <= evt_lvl;
      bal_q_r <= balance_active_status_i;
      int_cnt_r <= int_cnt_nxt;
      int_n_r <= (int_cnt_nxt == 16'h0000);
      top_sw_r <= ctrl_r[1] & ~auto_balance_enable_i;
      bot_sw_r <= ctrl_r[0] & ~auto_balance_enable_i;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = sda_oe_r;
  assign int_n_o = int_n_r;
  assign top_discharge_switch_o = top_sw_r;
  assign bottom_discharge_switch_o = bot_sw_r;

endmodule : cbfm_regs

// [verification/cbfm_regs_chk.sv]
// Purpose: Port checker of the balance flag and mask registers
// Assumes: One clock domain, rstn_i async low
// Notes: Bound into cbfm_regs
`timescale 1ns/100ps
`include "cbfm_defines.svh"
module cbfm_regs_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Conditions
  input wire logic balance_active_status_i,
  input wire logic upper_switch_constv_i,
  input wire logic lower_switch_constv_i,
  input wire logic upper_cell_overvolt_i,
  input wire logic lower_cell_overvolt_i,
  input wire logic balance_overcurrent_i,
  input wire logic auto_balance_enable_i,
  input wire logic reg_reset_i,
  // Outputs
  input wire logic top_discharge_switch_o,
  input wire logic bottom_discharge_switch_o,
  input wire logic int_n_o
);
  localparam int PW = `CBFM_INT_PULSE_CYC;
  logic [5:0] c_r;
  logic [3:0] e_r;
  logic [9:0] n_r;
  wire [5:0] c = {balance_active_status_i, upper_switch_constv_i, lower_switch_constv_i,
    upper_cell_overvolt_i, lower_cell_overvolt_i, balance_overcurrent_i};
  wire ev = (|(c[4:0] & ~c_r[4:0])) | (c[5] ^ c_r[5]);
  // Event history and low-time count
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      c_r <= 6'h00;
      e_r <= 4'h0;
      n_r <= 10'h000;
    end
    else
    begin
      c_r <= c;
      e_r <= {e_r[2:0], ev};
      n_r <= int_n_o ? 10'h000 : n_r + 10'h001;
    end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_top_auto: assert property (auto_balance_enable_i |=> !top_discharge_switch_o)
    else $error("top switch on in auto");
  a_bot_auto: assert property (auto_balance_enable_i |=> !bottom_discharge_switch_o)
    else $error("bottom switch on in auto");
  a_top_src: assert property ($rose(top_discharge_switch_o) |-> !$past(auto_balance_enable_i))
    else $error("top switch rose in auto");
  a_bot_src: assert property ($rose(bottom_discharge_switch_o) |-> !$past(auto_balance_enable_i))
    else $error("bottom switch rose in auto");
  a_sw_regrst: assert property (reg_reset_i |=> ##1 !top_discharge_switch_o && !bottom_discharge_switch_o)
    else $error("switch on after register reset");
  a_int_cause: assert property ($fell(int_n_o) |-> ev || (|e_r))
    else $error("interrupt without event");
  a_int_hold: assert property ($fell(int_n_o) |=> !int_n_o [*8])
    else $error("interrupt pulse cut short");
  a_int_width: assert property ($rose(int_n_o) |-> n_r >= PW)
    else $error("interrupt pulse too short");
endmodule : cbfm_regs_chk

bind cbfm_regs cbfm_regs_chk chk (
  .clk_i(clk_i),
  .rstn_i(rstn_i),
  .balance_active_status_i(balance_active_status_i),
  .upper_switch_constv_i(upper_switch_constv_i),
  .lower_switch_constv_i(lower_switch_constv_i),
  .upper_cell_overvolt_i(upper_cell_overvolt_i),
  .lower_cell_overvolt_i(lower_cell_overvolt_i),
  .balance_overcurrent_i(balance_overcurrent_i),
  .auto_balance_enable_i(auto_balance_enable_i),
  .reg_reset_i(reg_reset_i),
  .top_discharge_switch_o(top_discharge_switch_o),
  .bottom_discharge_switch_o(bottom_discharge_switch_o),
  .int_n_o(int_n_o)
);

// [verification/cbfm_host.sv]
// Purpose: I2C host model with interrupt watch
// Assumes: 4 clk per SCL phase, 6 clk in the SCL high phase of start and stop
// Notes: Read result carries a new-interrupt bit
`timescale 1ns/100ps
`include "cbfm_defines.svh"
module cbfm_host (
  // Clock
  input wire logic clk_i,
  // Bus
  input wire logic sda_i,
  input wire logic int_n_i,
  output logic scl_o,
  output logic low_o,
  // Result
  output logic [8:0] q_o,
  output logic v_o
);
  int n_int = 0;
  int n_last = 0;
  initial
  begin
    scl_o = 1'b1;
    low_o = 1'b0;
    q_o = 9'h000;
    v_o = 1'b0;
  end
  always @(negedge int_n_i) n_int++;
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask : w
  // Start when p is 0, stop when 1
  task automatic st(input logic p);
    scl_o <= 1'b0;
    w(2);
    low_o <= p;
    w(2);
    scl_o <= 1'b1;
    w(3);
    low_o <= ~p;
    w(3);
  endtask : st
  task automatic bt(input logic b, output logic r);
    scl_o <= 1'b0;
    w(2);
    low_o <= ~b;
    w(2);
    scl_o <= 1'b1;
    w(2);
    r = sda_i;
    w(2);
  endtask : bt
  task automatic by(input logic [7:0] d, output logic [7:0] q);
    logic k;
    for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
    bt(1'b1, k);
  endtask : by
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] q;
    st(1'b0);
    by({`CBFM_I2C_DEV_ADDR, 1'b0}, q);
    by(p, q);
    by(d, q);
    st(1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] p);
    logic [7:0] q;
    st(1'b0);
    by({`CBFM_I2C_DEV_ADDR, 1'b0}, q);
    by(p, q);
    st(1'b0);
    by({`CBFM_I2C_DEV_ADDR, 1'b1}, q);
    by(8'hFF, q);
    st(1'b1);
    q_o <= {n_int != n_last, q};
    n_last = n_int;
    v_o <= 1'b1;
    w(1);
    v_o <= 1'b0;
  endtask : rd
endmodule : cbfm_host

// [verification/testbench.sv]
// Purpose: Self-checking bench of the balance registers
// Assumes: Host model does the I2C cycles
// Notes: Expected bytes queued, compared on read
`timescale 1ns/100ps
`include "cbfm_defines.svh"
module testbench;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [4:0] cnd = 5'h00;
  logic bst = 1'b0;
  logic aut = 1'b1;
  logic rr = 1'b0;
  logic sda_o, sda_oe_o, scl, low, top, bot, int_n, v;
  logic [8:0] q;
  logic [8:0] eq[$];
  logic [31:0] x = 32'h4A;
  logic [7:0] r;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  wire sda_i = ~(sda_oe_o | low);
  localparam logic [7:0] FA = `CBFM_ADDR_FLAG;
  localparam logic [7:0] MA = `CBFM_ADDR_MASK;
  cbfm_regs uut (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .balance_active_status_i(bst), .upper_switch_constv_i(cnd[4]),
    .lower_switch_constv_i(cnd[3]), .upper_cell_overvolt_i(cnd[2]), .lower_cell_overvolt_i(cnd[1]),
    .balance_overcurrent_i(cnd[0]), .auto_balance_enable_i(aut), .reg_reset_i(rr),
    .top_discharge_switch_o(top), .bottom_discharge_switch_o(bot), .int_n_o(int_n));
  cbfm_host h (.clk_i(clk_i), .sda_i(sda_i), .int_n_i(int_n), .scl_o(scl), .low_o(low), .q_o(q), .v_o(v));
  initial forever #2 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, s, e);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic ex(input logic [7:0] p, input logic [8:0] e);
    eq.push_back(e);
    h.rd(p);
  endtask : ex
  task automatic regrst;
    rr <= 1'b1;
    @(posedge clk_i);
    rr <= 1'b0;
  endtask : regrst
  always @(posedge clk_i) if (v) check(q, eq.pop_front());
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    ex(FA, 9'h000);
    ex(MA, 9'h000);
    aut <= 1'b0;
    h.wr(FA, 8'hFF);
    ex(FA, 9'h0C0);
    check({7'h00, top, bot}, 9'h003);
    cnd <= 5'h04;
    ex(FA, 9'h1C4);
    ex(FA, 9'h0C4);
    cnd <= 5'h00;
    aut <= 1'b1;
    ex(FA, 9'h0C4);
    ex(FA, 9'h0C0);
    check({7'h00, top, bot}, 9'h000);
    aut <= 1'b0;
    regrst();
    ex(FA, 9'h000);
    check({7'h00, top, bot}, 9'h000);
    bst <= 1'b1;
    ex(FA, 9'h120);
    ex(FA, 9'h000);
    h.wr(MA, 8'h20);
    bst <= 1'b0;
    ex(FA, 9'h020);
    for (int k = 0; k < 5; k++)
    begin
      x = xs(x);
      r = x[7:0];
      h.wr(MA, r);
      cnd[k] <= 1'b1;
      repeat (2) @(posedge clk_i);
      cnd[k] <= 1'b0;
      ex(FA, {~r[k], 8'h01 << k});
      ex(MA, {1'b0, r & 8'h3F});
    end
    regrst();
    ex(MA, 9'h000);
    @(posedge clk_i);
    summarize();
  end
endmodule : testbench
